// ==== src/ccsr_pkg.sv ====
// ccsr_pkg: constants, fields and carriers of the core special register set
// assumes a byte-wide special register port driven by the execution unit
package ccsr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_IDENT_UNLCK = 8'hA1;
  localparam logic [7:0] ADDR_GLOBAL_CFG  = 8'hB1;
  localparam logic [7:0] ADDR_STATUS      = 8'hD0;
  localparam logic [7:0] ADDR_OPERAND     = 8'hE0;
  localparam logic [7:0] ADDR_MULDIV      = 8'hF0;
  // reset values
  localparam logic [7:0] RST_STACK_TOP    = 8'h07;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_POWER_CTRL   = 8'h10;
  localparam logic [7:0] CFG_BOOT_VALUE   = 8'hA0;
  localparam logic [7:0] CFG_APP_VALUE    = 8'h80;
  // global configuration layout
  localparam int         CFG_BOOT_BIT     = 5;
  localparam int         CFG_SWRST_BIT    = 4;
  localparam logic [7:0] CFG_RW_MASK      = 8'h1F;
  // status word field positions
  localparam int         ST_CARRY         = 7;
  localparam int         ST_HALF          = 6;
  localparam int         ST_USER0         = 5;
  localparam int         ST_BANK_HI       = 4;
  localparam int         ST_BANK_LO       = 3;
  localparam int         ST_SIGNED        = 2;
  localparam int         ST_USER1         = 1;
  localparam int         ST_PARITY        = 0;
  localparam logic [7:0] ST_PARITY_MASK   = 8'h01;
  // unlock sequence
  localparam logic [7:0] UNLOCK_FIRST     = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND    = 8'hAA;
  localparam int         UNLOCK_MIN_CYC   = 13;
  localparam int         UNLOCK_MAX_CYC   = 23;
  localparam logic [4:0] UNLOCK_WIN_CYC   = 5'h12;
  // bank base spacing: eight registers per bank
  localparam int         BANK_SHIFT       = 3;

  typedef enum logic [3:0] {
    CCSR_OP_NONE, CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB, CCSR_OP_MUL,
    CCSR_OP_DIV, CCSR_OP_CARRY_ONLY, CCSR_OP_SET_CARRY, CCSR_OP_CLR_CARRY
  } ccsr_flag_op_type;

  // byte or bit access from the execution unit
  typedef struct packed {
    logic       wr;
    logic       bit_mode;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ccsr_access_type;

  // arithmetic flag update request
  typedef struct packed {
    ccsr_flag_op_type op;
    logic             carry;
    logic             half;
    logic             signed_ovf;
  } ccsr_flags_type;

  // stack request: push increments first, pop decrements after read
  typedef struct packed {
    logic push;
    logic pop;
  } ccsr_stack_type;
endpackage : ccsr_pkg

// ==== src/ccsr_unlock_window.sv ====
// ccsr_unlock_window: two-step unlock and timed protected-write window
// assumes one write strobe per access to the unlock address
`timescale 1ns/1ps
`default_nettype none
module ccsr_unlock_window
  import ccsr_pkg::*;
#(
  parameter logic [4:0] WIN_CYC = UNLOCK_WIN_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // unlock register writes
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // window state
  output logic            window_open
);
  typedef enum logic [1:0] {ccsr_idle, ccsr_armed, ccsr_open} ccsr_win_state_type;
  ccsr_win_state_type state_q, state_d;
  logic [4:0]         count_q, count_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      ccsr_idle: begin
        if (wr_en && wr_data == UNLOCK_FIRST) state_d = ccsr_armed;
      end
      ccsr_armed: begin
        if (wr_en) begin
          // a repeated first byte keeps the sequence armed
          state_d = (wr_data == UNLOCK_SECOND) ? ccsr_open :
                    (wr_data == UNLOCK_FIRST)  ? ccsr_armed : ccsr_idle;
          count_d = WIN_CYC;
        end
      end
      ccsr_open: begin
        count_d = count_q - 5'h01;
        if (wr_en || count_q == 5'h01) state_d = ccsr_idle;
      end
      default: state_d = ccsr_idle;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ccsr_idle;
      count_q <= 5'h00;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign window_open = (state_q == ccsr_open);
endmodule : ccsr_unlock_window
`default_nettype wire

// ==== src/ccsr_pointer_pair.sv ====
// ccsr_pointer_pair: two physical 16-bit data pointers with a selector
// assumes the select bit comes from the bus auxiliary configuration
`timescale 1ns/1ps
`default_nettype none
module ccsr_pointer_pair
  import ccsr_pkg::*;
#(
  parameter int PTR_COUNT = 2
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // selection and byte writes
  input  wire logic        pointer_set_choice,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wr_data,
  // whole-word update from pointer instructions
  input  wire logic        word_wr,
  input  wire logic [15:0] word_data,
  // active pointer
  output logic      [15:0] pointer_pair_word
);
  logic [15:0] ptr_q [PTR_COUNT];

  genvar g;
  generate
    for (g = 0; g < PTR_COUNT; g++) begin : g_ptr
      wire logic sel = (int'(pointer_set_choice) == g);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) ptr_q[g] <= {RST_ZERO, RST_ZERO};
        else if (sel && word_wr) ptr_q[g] <= word_data;
        else if (sel && wr_low) ptr_q[g][7:0] <= wr_data;
        else if (sel && wr_high) ptr_q[g][15:8] <= wr_data;
      end
    end
  endgenerate

  assign pointer_pair_word = ptr_q[pointer_set_choice];
endmodule : ccsr_pointer_pair
`default_nettype wire

// ==== src/ccsr_core_regs.sv ====
// ccsr_core_regs: special function register set of the 8-bit core
// assumes the execution unit drives one access per cycle, reads are combinational
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_regs
  import ccsr_pkg::*;
#(
  parameter logic [7:0] IDENTITY_CODE = 8'h3C, // arbitrary value
  parameter logic [4:0] WIN_CYC       = UNLOCK_WIN_CYC
) (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  // register access from the execution unit
  input  wire ccsr_access_type acc,
  output logic           [7:0] rdata,
  // arithmetic results
  input  wire ccsr_flags_type  flags,
  input  wire logic            operand_wr,
  input  wire logic      [7:0] operand_data,
  // stack operations
  input  wire ccsr_stack_type  stack,
  // pointer instructions
  input  wire logic            pointer_word_wr,
  input  wire logic     [15:0] pointer_word_data,
  input  wire logic            pointer_set_choice,
  // state shown to the core
  output logic           [7:0] primary_operand_register,
  output logic           [7:0] multiply_divide_register,
  output logic           [7:0] cpu_status_flags,
  output logic           [7:0] stack_top_pointer,
  output logic          [15:0] pointer_pair_word,
  output logic           [4:0] bank_base_addr,
  output logic           [7:0] power_control,
  output logic           [7:0] global_configuration,
  output logic                 protected_window,
  output logic                 soft_reset_req
);
  logic       rst_meta_q, rst_n_q;
  logic [7:0] operand_q, muldiv_q, status_q, stack_q, power_q, cfg_q;
  logic [7:0] operand_d, muldiv_d, status_d, stack_d, cfg_d;
  logic       boot_q;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // merge a byte or a single-bit write
  function automatic logic [7:0] merge_write(input logic [7:0] cur,
                                             input ccsr_access_type a);
    logic [7:0] r;
    r = cur;
    if (a.bit_mode) r[a.bit_sel] = a.wdata[0];
    else r = a.wdata;
    return r;
  endfunction

  function automatic logic hit(input ccsr_access_type a, input logic [7:0] addr);
    return a.wr && (a.addr == addr);
  endfunction

  wire logic wr_operand = hit(acc, ADDR_OPERAND);
  wire logic wr_muldiv  = hit(acc, ADDR_MULDIV);
  wire logic wr_status  = hit(acc, ADDR_STATUS);
  wire logic wr_stack   = hit(acc, ADDR_STACK_TOP);
  wire logic wr_power   = hit(acc, ADDR_POWER_CTRL);
  wire logic wr_unlock  = hit(acc, ADDR_IDENT_UNLCK);
  wire logic wr_cfg     = hit(acc, ADDR_GLOBAL_CFG);
  wire logic wr_ptr_lo  = hit(acc, ADDR_PTR_LOW);
  wire logic wr_ptr_hi  = hit(acc, ADDR_PTR_HIGH);

  // operand: arithmetic result port wins over a register write
  // bit writes on operand
  assign operand_d = operand_wr ? operand_data :
                     wr_operand ? merge_write(operand_q, acc) : operand_q;
  assign muldiv_d  = wr_muldiv ? merge_write(muldiv_q, acc) : muldiv_q;

  // status word: software write first, then flags from the instruction
  logic [7:0] status_sw;
  assign status_sw = wr_status ? merge_write(status_q, acc) : status_q;

  always_comb begin
    status_d = status_sw;
    case (flags.op)
      CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB: begin
        status_d[ST_CARRY]  = flags.carry;
        status_d[ST_HALF]   = flags.half;
        status_d[ST_SIGNED] = flags.signed_ovf;
      end
      CCSR_OP_MUL, CCSR_OP_DIV: begin
        status_d[ST_CARRY]  = 1'b0;
        status_d[ST_SIGNED] = flags.signed_ovf;
      end
      CCSR_OP_CARRY_ONLY: status_d[ST_CARRY] = flags.carry;
      CCSR_OP_SET_CARRY:  status_d[ST_CARRY] = 1'b1;
      CCSR_OP_CLR_CARRY:  status_d[ST_CARRY] = 1'b0;
      default: status_d = status_sw;
    endcase
    status_d[ST_PARITY] = ^operand_d;
  end

  assign stack_d = stack.push ? stack_q + 8'h01 :
                   stack.pop  ? stack_q - 8'h01 :
                   wr_stack   ? acc.wdata : stack_q;

  // protected write window
  ccsr_unlock_window #(
    .WIN_CYC (WIN_CYC)
  ) u_unlock (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n_q),
    .wr_en       (wr_unlock),
    .wr_data     (acc.wdata),
    .window_open (protected_window)
  );

  logic [7:0] cfg_held;
  always_comb begin
    cfg_held = cfg_q;
    cfg_held[CFG_SWRST_BIT] = 1'b0;
  end

  assign cfg_d = (wr_cfg && protected_window) ?
                 ((cfg_q & ~CFG_RW_MASK) | (merge_write(cfg_q, acc) & CFG_RW_MASK)) :
                 cfg_held;

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      operand_q <= RST_ZERO;
      muldiv_q  <= RST_ZERO;
      status_q  <= RST_ZERO;
      stack_q   <= RST_STACK_TOP;
      power_q   <= RST_POWER_CTRL;
      cfg_q     <= CFG_APP_VALUE;
      boot_q    <= 1'b1;
    end else begin
      operand_q <= operand_d;
      muldiv_q  <= muldiv_d;
      status_q  <= status_d;
      stack_q   <= stack_d;
      if (wr_power) power_q <= merge_write(power_q, acc);
      cfg_q     <= cfg_d;
      // boot flag drops once software reset is requested
      if (cfg_q[CFG_SWRST_BIT]) boot_q <= 1'b0;
    end
  end

  ccsr_pointer_pair #(
    .PTR_COUNT (2)
  ) u_ptr (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n_q),
    .pointer_set_choice (pointer_set_choice),
    .wr_low             (wr_ptr_lo),
    .wr_high            (wr_ptr_hi),
    .wr_data            (acc.wdata),
    .word_wr            (pointer_word_wr),
    .word_data          (pointer_word_data),
    .pointer_pair_word  (pointer_pair_word)
  );

  wire logic [7:0] cfg_view = {cfg_q[7:6], boot_q, cfg_q[4:0]};

  // read mux; unmapped reads as zero
  always_comb begin
    case (acc.addr)
      ADDR_OPERAND:     rdata = operand_q;
      ADDR_MULDIV:      rdata = muldiv_q;
      ADDR_STATUS:      rdata = status_q;
      ADDR_STACK_TOP:   rdata = stack_q;
      ADDR_PTR_LOW:     rdata = pointer_pair_word[7:0];
      ADDR_PTR_HIGH:    rdata = pointer_pair_word[15:8];
      ADDR_POWER_CTRL:  rdata = power_q;
      ADDR_IDENT_UNLCK: rdata = IDENTITY_CODE;
      ADDR_GLOBAL_CFG:  rdata = cfg_view;
      default:          rdata = RST_ZERO;
    endcase
  end

  assign primary_operand_register = operand_q;
  assign multiply_divide_register = muldiv_q;
  assign cpu_status_flags         = status_q;
  assign stack_top_pointer        = stack_q;
  assign bank_base_addr = {status_q[ST_BANK_HI:ST_BANK_LO], 3'h0};
  assign power_control            = power_q;
  assign global_configuration     = cfg_view;
  assign soft_reset_req           = cfg_q[CFG_SWRST_BIT];
endmodule : ccsr_core_regs
`default_nettype wire

// ==== sim/ccsr_assertions.sv ====
// ccsr_assertions: port-level checks of the special register set
// assumes it is bound onto ccsr_core_regs
`timescale 1ns/1ps
`default_nettype none
module ccsr_assertions
  import ccsr_pkg::*;
#(
  parameter logic [4:0] WIN_CYC = UNLOCK_WIN_CYC
) (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            arst_n,
  // requests
  input wire ccsr_access_type acc,
  input wire ccsr_flags_type  flags,
  input wire ccsr_stack_type  stack,
  // state
  input wire logic      [7:0] primary_operand_register,
  input wire logic      [7:0] cpu_status_flags,
  input wire logic      [7:0] stack_top_pointer,
  input wire logic      [4:0] bank_base_addr,
  input wire logic      [7:0] global_configuration,
  input wire logic            protected_window
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [4:0] open_cnt_q;
  wire logic  a1_wr = acc.wr && acc.addr == ADDR_IDENT_UNLCK;
  wire logic  b1_wr = acc.wr && acc.addr == ADDR_GLOBAL_CFG;
  // length of the current open window
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) open_cnt_q <= 5'h00;
    else open_cnt_q <= protected_window ? open_cnt_q + 5'h01 : 5'h00;
  sequence s_first;  !protected_window && a1_wr && acc.wdata == UNLOCK_FIRST;  endsequence
  sequence s_second; a1_wr && acc.wdata == UNLOCK_SECOND; endsequence
  AST_UNLOCK_OPEN: assert property (s_first ##1 s_second |=> protected_window)
    else $error("window not opened by unlock pair");
  AST_WIN_CLOSE: assert property (protected_window && a1_wr |=> !protected_window)
    else $error("window not closed by unlock write");
  AST_WIN_MAX: assert property (open_cnt_q <= UNLOCK_MAX_CYC)
    else $error("window open too long");
  AST_WIN_MIN: assert property ($fell(protected_window) && !$past(a1_wr) |->
    open_cnt_q >= UNLOCK_MIN_CYC)
    else $error("window closed too early");
  AST_CFG_LOCK: assert property (!protected_window && b1_wr &&
    !global_configuration[CFG_SWRST_BIT] |=> $stable(global_configuration))
    else $error("configuration changed while locked");
  AST_PARITY: assert property (cpu_status_flags[ST_PARITY] == ^primary_operand_register)
    else $error("parity flag wrong");
  AST_BANK: assert property (bank_base_addr == {cpu_status_flags[ST_BANK_HI:ST_BANK_LO], 3'h0})
    else $error("bank base wrong");
  AST_ARITH: assert property (flags.op inside {CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB} |=>
    cpu_status_flags[ST_CARRY] == $past(flags.carry) && cpu_status_flags[ST_HALF] ==
    $past(flags.half) && cpu_status_flags[ST_SIGNED] == $past(flags.signed_ovf))
    else $error("arithmetic flags wrong");
  AST_MULDIV: assert property (flags.op inside {CCSR_OP_MUL, CCSR_OP_DIV} |=>
    !cpu_status_flags[ST_CARRY] && cpu_status_flags[ST_SIGNED] == $past(flags.signed_ovf))
    else $error("multiply or divide flags wrong");
  AST_SET_CLR: assert property (flags.op inside {CCSR_OP_SET_CARRY, CCSR_OP_CLR_CARRY} |=>
    cpu_status_flags[ST_CARRY] == ($past(flags.op) == CCSR_OP_SET_CARRY))
    else $error("forced carry wrong");
  AST_PUSH: assert property (stack.push |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not increment");
  AST_POP: assert property (stack.pop && !stack.push |=>
    stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("pop did not decrement");
endmodule : ccsr_assertions
bind ccsr_core_regs ccsr_assertions #(.WIN_CYC(WIN_CYC)) chk_u (.sys_clk, .arst_n, .acc, .flags,
  .stack, .primary_operand_register, .cpu_status_flags, .stack_top_pointer, .bank_base_addr,
  .global_configuration, .protected_window);
`default_nettype wire

// ==== sim/ccsr_exec_model.sv ====
// ccsr_exec_model: execution unit stand-in producing results and flags
// assumes its tasks are entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ccsr_exec_model
  import ccsr_pkg::*;
(
  // clock
  input  wire logic         sys_clk,
  // requests toward the register set
  output var ccsr_flags_type flags,
  output logic              operand_wr,
  output logic        [7:0] operand_data,
  output var ccsr_stack_type stack,
  output logic              pointer_word_wr,
  output logic       [15:0] pointer_word_data
);
  initial begin
    flags = '0;
    stack = '0;
    {operand_wr, operand_data, pointer_word_wr, pointer_word_data} = '0;
  end
  task automatic alu(input ccsr_flag_op_type op, input logic [7:0] a, input logic [7:0] b,
                     input logic cin);
    ccsr_flags_type f;
    logic [15:0]    r;
    f = '{op: op, carry: cin, default: 1'b0};
    r = '0;
    case (op)
      CCSR_OP_ADD, CCSR_OP_ADDC: begin
        r = 16'(a) + 16'(b) + 16'(cin);
        f.carry = r[8];
        f.half = (5'(a[3:0]) + 5'(b[3:0]) + 5'(cin)) > 5'h0F;
        f.signed_ovf = (a[7] == b[7]) && (r[7] != a[7]);
      end
      CCSR_OP_SUBB: begin
        r = 16'(a) - 16'(b) - 16'(cin);
        f.carry = r[8];
        f.half = 5'(a[3:0]) < 5'(b[3:0]) + 5'(cin);
        f.signed_ovf = (a[7] != b[7]) && (r[7] != a[7]);
      end
      CCSR_OP_MUL: begin
        r = 16'(a) * 16'(b);
        f.signed_ovf = |r[15:8];
      end
      CCSR_OP_DIV: begin
        r = 16'(a / b);
        f.signed_ovf = (b == 8'h00);
      end
      default: r = '0;
    endcase
    flags = f;
    operand_wr = op inside {CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB, CCSR_OP_MUL, CCSR_OP_DIV};
    operand_data = r[7:0];
    @(posedge sys_clk);
    #1;
    flags = '0;
    operand_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : alu
  task automatic stk(input logic push, input logic pop);
    stack = '{push: push, pop: pop};
    @(posedge sys_clk);
    #1;
    stack = '0;
    @(posedge sys_clk);
    #1;
  endtask : stk
  task automatic wd(input logic [15:0] d);
    {pointer_word_wr, pointer_word_data} = {1'b1, d};
    @(posedge sys_clk);
    #1;
    pointer_word_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wd
endmodule : ccsr_exec_model
`default_nettype wire

// ==== sim/ccsr_core_regs_bench.sv ====
// ccsr_core_regs_bench: register access sequences against the special register set
// assumes the execution unit model drives the arithmetic and stack requests
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_regs_bench
  import ccsr_pkg::*;
;
  localparam logic [7:0] ID_CODE = 8'h5A; // arbitrary value
  logic sys_clk, arst_n, pointer_set_choice, operand_wr, pointer_word_wr, protected_window;
  logic soft_reset_req;
  logic [7:0] rdata, operand_data;
  logic [15:0] pointer_word_data, pointer_pair_word;
  logic [4:0] bank_base_addr;
  ccsr_access_type acc;
  ccsr_flags_type flags;
  ccsr_stack_type stack;
  int n_errors = 0, checks = 0, n;
  logic [7:0] r_a [10] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hA1, 8'hB1, 8'hD0, 8'hE0, 8'hF0, 8'h90};
  logic [7:0] r_v [10] = '{8'h07, 8'h00, 8'h00, 8'h10, ID_CODE, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00};
  ccsr_flag_op_type t_op [8] = '{CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB, CCSR_OP_MUL,
    CCSR_OP_DIV, CCSR_OP_SET_CARRY, CCSR_OP_CLR_CARRY, CCSR_OP_CARRY_ONLY};
  logic [7:0] t_a [8] = '{8'h7F, 8'h80, 8'h00, 8'h10, 8'h09, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_b [8] = '{8'h01, 8'h80, 8'h01, 8'h10, 8'h03, 8'h01, 8'h01, 8'h01};
  logic       t_c [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] t_s [8] = '{8'h45, 8'h85, 8'hC0, 8'h44, 8'h40, 8'hC0, 8'h40, 8'hC0};

  ccsr_core_regs #(.IDENTITY_CODE(ID_CODE)) dut_u (.sys_clk, .arst_n, .acc, .rdata, .flags,
    .operand_wr, .operand_data, .stack, .pointer_word_wr, .pointer_word_data,
    .pointer_set_choice, .primary_operand_register(), .multiply_divide_register(),
    .cpu_status_flags(), .stack_top_pointer(), .pointer_pair_word, .bank_base_addr,
    .power_control(), .global_configuration(), .protected_window, .soft_reset_req);
  ccsr_exec_model exu_u (.sys_clk, .flags, .operand_wr, .operand_data, .stack,
    .pointer_word_wr, .pointer_word_data);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bm, input logic [2:0] bs);
    acc = '{wr: 1'b1, bit_mode: bm, addr: a, bit_sel: bs, wdata: d};
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc = '{addr: a, default: '0};
    #1;
    cmp({8'h00, rdata}, {8'h00, exp});
    @(posedge sys_clk);
    #1;
  endtask : rd
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    #20000;
    n_errors++;
    $display("ERROR %0t: timeout", $time);
    results();
  end
  initial begin
    acc = '0;
    pointer_set_choice = 1'b0;
    arst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    foreach (r_a[i]) rd(r_a[i], r_v[i]);
    $display("test reset values done");
    foreach (t_op[i]) begin
      exu_u.alu(t_op[i], t_a[i], t_b[i], t_c[i]);
      rd(ADDR_STATUS, t_s[i]);
    end
    $display("test arithmetic flags done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_STATUS, 8'(i << 3) | 8'h01, 1'b0, 3'h0);
      rd(ADDR_STATUS, 8'(i << 3));
      cmp({11'h000, bank_base_addr}, 16'(i * 8));
    end
    wr(ADDR_STATUS, 8'h01, 1'b1, 3'h5);
    wr(ADDR_STATUS, 8'h01, 1'b1, 3'h1);
    wr(ADDR_OPERAND, 8'h01, 1'b1, 3'h7);
    wr(ADDR_MULDIV, 8'h01, 1'b1, 3'h2);
    rd(ADDR_STATUS, 8'h3B);
    rd(ADDR_OPERAND, 8'h83);
    rd(ADDR_MULDIV, 8'h04);
    $display("test status bits done");
    exu_u.stk(1'b1, 1'b0);
    exu_u.stk(1'b1, 1'b0);
    rd(ADDR_STACK_TOP, 8'h09);
    exu_u.stk(1'b0, 1'b1);
    rd(ADDR_STACK_TOP, 8'h08);
    $display("test stack done");
    wr(ADDR_PTR_LOW, 8'h34, 1'b0, 3'h0);
    wr(ADDR_PTR_HIGH, 8'h12, 1'b0, 3'h0);
    rd(ADDR_PTR_HIGH, 8'h12);
    pointer_set_choice = 1'b1;
    rd(ADDR_PTR_LOW, 8'h00);
    exu_u.wd(16'hBEEF);
    cmp(pointer_pair_word, 16'hBEEF);
    pointer_set_choice = 1'b0;
    rd(ADDR_PTR_LOW, 8'h34);
    cmp(pointer_pair_word, 16'h1234);
    $display("test pointers done");
    wr(ADDR_GLOBAL_CFG, 8'h01, 1'b0, 3'h0);
    rd(ADDR_GLOBAL_CFG, 8'hA0);
    wr(ADDR_IDENT_UNLCK, 8'h55, 1'b0, 3'h0);
    wr(ADDR_IDENT_UNLCK, 8'hAA, 1'b0, 3'h0);
    wr(ADDR_GLOBAL_CFG, 8'h0D, 1'b0, 3'h0);
    rd(ADDR_GLOBAL_CFG, 8'hAD);
    rd(ADDR_IDENT_UNLCK, ID_CODE);
    n = 3;
    while (protected_window && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp(16'(n >= UNLOCK_MIN_CYC && n <= UNLOCK_MAX_CYC), 16'h0001);
    wr(ADDR_GLOBAL_CFG, 8'h00, 1'b0, 3'h0);
    rd(ADDR_GLOBAL_CFG, 8'hAD);
    wr(ADDR_IDENT_UNLCK, 8'h55, 1'b0, 3'h0);
    wr(ADDR_IDENT_UNLCK, 8'hAA, 1'b0, 3'h0);
    cmp({15'h0000, protected_window}, 16'h0001);
    wr(ADDR_IDENT_UNLCK, 8'h00, 1'b0, 3'h0);
    cmp({15'h0000, protected_window}, 16'h0000);
    wr(ADDR_IDENT_UNLCK, 8'h55, 1'b0, 3'h0);
    wr(ADDR_IDENT_UNLCK, 8'hAA, 1'b0, 3'h0);
    wr(ADDR_GLOBAL_CFG, 8'h10, 1'b0, 3'h0);
    cmp({15'h0000, soft_reset_req}, 16'h0001);
    rd(ADDR_STACK_TOP, 8'h08);
    rd(ADDR_GLOBAL_CFG, 8'h80);
    cmp({15'h0000, soft_reset_req}, 16'h0000);
    $display("test protected window done");
    results();
  end
endmodule : ccsr_core_regs_bench
`default_nettype wire
